//--- pinmux_pkg.sv
// Constants, codes and register map of the line function and I/O port
// Notes on behaviour
// - Line 9 carries receive toggle when bit 9 set
// - Line 8 carries transmit toggle when bit 8 set
// - Line 6 outputs clock when bit 7 set
// - Field 6:5 picks line 7 transceiver enable kind
// - Pin choice bit 4 routes enable to line 7
// - Polarity bit 3 picks enable active level
// - Low mode 000 keeps handshake lines general purpose
// - Codes 001, 010 hand lines to flow control
// - Codes 011, 100 make line 5 transceiver enable
// - Direction bit: 0 input, 1 output, general only
// - Direction ignored on alternate function lines
// - Set write drives general outputs high per bit
// - Clear write drives general outputs low per bit
// - Set and clear skip inputs and alternates
// - State read returns true level of all lines
// - State write drives general outputs to bits
// - Unmasked input change raises event; mask resets 0x100
// - Mask covers inputs on alternate functions too
// - Masked lines still report their level
// - Enable held programmed bit times after transmit
package pinmux_pkg;

  localparam int LINE_W = 10;
  localparam int REG_W  = 16;
  localparam int ADDR_W = 8;
  localparam int TURN_W = 4;

  // Register offsets as printed
  localparam logic [ADDR_W-1:0] OFS_TURNAROUND = 8'h0B;
  localparam logic [ADDR_W-1:0] OFS_FUNC       = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_DIRECTION  = 8'h0D;
  localparam logic [ADDR_W-1:0] OFS_SET        = 8'h0E;
  localparam logic [ADDR_W-1:0] OFS_CLEAR      = 8'h0F;
  localparam logic [ADDR_W-1:0] OFS_LEVEL      = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_MASK       = 8'h11;

  // Values after reset
  localparam logic [LINE_W-1:0] FUNC_RST       = 10'h300;
  localparam logic [LINE_W-1:0] DIR_RST        = 10'h000;
  localparam logic [LINE_W-1:0] LEVEL_RST      = 10'h000;
  localparam logic [LINE_W-1:0] MASK_RST       = 10'h100;
  localparam logic [TURN_W-1:0] TURNAROUND_RST = 4'h0;

  // Fields of the function select register
  localparam int FS_RX_TOGGLE = 9;
  localparam int FS_TX_TOGGLE = 8;
  localparam int FS_CLK_EN    = 7;
  localparam int FS_SEL7_HI   = 6;
  localparam int FS_SEL7_LO   = 5;
  localparam int FS_PIN_SEL   = 4;
  localparam int FS_POLARITY  = 3;
  localparam int FS_LMODE_HI  = 2;
  localparam int FS_LMODE_LO  = 0;

  // Line numbers of the alternate functions
  localparam int LN_RX_TOGGLE = 9;
  localparam int LN_TX_TOGGLE = 8;
  localparam int LN_XCVR7     = 7;
  localparam int LN_CLOCK     = 6;
  localparam int LN_REQUEST   = 5;
  localparam int LN_CLEAR_IN  = 4;
  localparam int LN_READY_IN  = 3;
  localparam int LN_TERMINAL  = 2;

  // Line 7 transceiver select codes
  localparam logic [1:0] XE_GPIO     = 2'h0;
  localparam logic [1:0] XE_TRANSMIT = 2'h1;
  localparam logic [1:0] XE_MATCH    = 2'h2;

  // Low mode codes
  localparam logic [2:0] LM_GPIO     = 3'h0;
  localparam logic [2:0] LM_RTS_CTS  = 3'h1;
  localparam logic [2:0] LM_DTR_DSR  = 3'h2;
  localparam logic [2:0] LM_XCVR_TX  = 3'h3;
  localparam logic [2:0] LM_XCVR_ADR = 3'h4;

  // Transceiver enable sequencer states
  typedef enum logic [2:0] {
    XS_IDLE = 3'h1,
    XS_ON   = 3'h2,
    XS_HOLD = 3'h4
  } xcvr_state_t;

endpackage

//--- xcvr_if.sv
// Connection between the port and one transceiver enable sequencer
`timescale 1ns/1ps
interface xcvr_if;
  import pinmux_pkg::*;
  logic              sel_match;
  logic [TURN_W-1:0] delay;
  logic              polarity;
  logic              tx_active;
  logic              addr_match;
  logic              bit_tick;
  logic              drive;

  modport ctrl (output sel_match, delay, polarity, tx_active, addr_match,
                output bit_tick, input drive);
  modport gen  (input sel_match, delay, polarity, tx_active, addr_match,
                input bit_tick, output drive);
endinterface

//--- xcvr_enable_gen.sv
// Transceiver enable sequencer with turnaround hold
`timescale 1ns/1ps
module xcvr_enable_gen
  import pinmux_pkg::*;
#(
  parameter int DELAY_W = TURN_W
) (
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  xcvr_if.gen       g
);

  if (DELAY_W != TURN_W) begin : g_bad_width
    $error("xcvr_enable_gen: DELAY_W must equal the delay field width");
  end

  xcvr_state_t       state_r;
  xcvr_state_t       state_nxt;
  logic [TURN_W-1:0] cnt_r;
  logic              act;
  logic              drive_r;

  // Enable source chosen by mode
  assign act = g.sel_match ? g.addr_match : g.tx_active;

  // Next state; hold counts bit ticks after the source drops
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      XS_IDLE: begin
        if (act) state_nxt = XS_ON;
      end
      XS_ON: begin
        if (!act) begin
          state_nxt = (g.delay == '0) ? XS_IDLE : XS_HOLD;
        end
      end
      XS_HOLD: begin
        if (act) state_nxt = XS_ON;
        else if (g.bit_tick && cnt_r == 4'h1) state_nxt = XS_IDLE;
      end
      default: state_nxt = XS_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) state_r <= XS_IDLE;
    else          state_r <= state_nxt;
  end

  // Bit time counter, loaded at the drop of the source
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
    end else if (state_r == XS_ON && !act) begin
      cnt_r <= g.delay;
    end else if (state_r == XS_HOLD && g.bit_tick && cnt_r != '0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end

  // Output level after polarity; idle level is the inactive one
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) drive_r <= 1'b1;
    else          drive_r <= (state_nxt != XS_IDLE) ~^ g.polarity;
  end

  assign g.drive = drive_r;

  en_follows_a :
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      act |=> (drive_r == $past(g.polarity)))
    else $error("enable not asserted while source active");

  hold_keeps_a :
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (state_r == XS_HOLD && cnt_r > 4'h1 && !act) |=> state_r == XS_HOLD)
    else $error("turnaround hold ended early");

  zero_delay_a :
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (state_r == XS_ON && !act && g.delay == 4'h0) |=> state_r == XS_IDLE)
    else $error("zero delay did not release enable");

endmodule // xcvr_enable_gen

//--- uart_pin_function_io_port.sv
// Line function multiplexer and general purpose port of one channel
`timescale 1ns/1ps
module uart_pin_function_io_port
  import pinmux_pkg::*;
(
  input  wire logic                          i_core_clk,
  input  wire logic                          i_rst_n,
  input  wire logic                          i_reg_wr,
  input  wire logic                          i_reg_rd,
  input  wire logic [pinmux_pkg::ADDR_W-1:0] i_reg_addr,
  input  wire logic [pinmux_pkg::REG_W-1:0]  i_reg_wdata,
  output logic      [pinmux_pkg::REG_W-1:0]  o_reg_rdata,
  output logic                               o_reg_rvalid,
  input  wire logic [pinmux_pkg::LINE_W-1:0] i_line_in,
  output logic      [pinmux_pkg::LINE_W-1:0] o_line_out,
  output logic      [pinmux_pkg::LINE_W-1:0] o_line_oe,
  input  wire logic                          i_rx_toggle,
  input  wire logic                          i_tx_toggle,
  input  wire logic                          i_clk_out,
  input  wire logic                          i_flow_request,
  input  wire logic                          i_flow_terminal,
  input  wire logic                          i_uart_tx_active,
  input  wire logic                          i_addr_match,
  input  wire logic                          i_bit_tick,
  output logic                               o_clear_level,
  output logic                               o_ready_level,
  output logic                               o_change_event,
  output logic      [pinmux_pkg::LINE_W-1:0] o_change_lines
);
  import pinmux_pkg::*;

  logic [LINE_W-1:0] func_r;
  logic [LINE_W-1:0] dir_r;
  logic [LINE_W-1:0] gpio_r;
  logic [LINE_W-1:0] mask_r;
  logic [TURN_W-1:0] turn_r;
  logic [LINE_W-1:0] sync1_r;
  logic [LINE_W-1:0] sync2_r;
  logic [LINE_W-1:0] level_r;
  logic              armed_r;
  logic [1:0]        arm_sh_r;
  logic [LINE_W-1:0] alt_mask;
  logic [LINE_W-1:0] alt_oe;
  logic [LINE_W-1:0] alt_val;
  logic [LINE_W-1:0] gp_out;
  logic [LINE_W-1:0] change_nxt;
  logic [LINE_W-1:0] wbits;
  logic [1:0]        sel7;
  logic [2:0]        lmode;
  logic              wr_func;
  logic              wr_dir;
  logic              wr_set;
  logic              wr_clear;
  logic              wr_level;
  logic              wr_mask;
  logic              wr_turn;
  logic              line7_xcvr;

  xcvr_if x5 ();
  xcvr_if x7 ();

  // Field views and write decode
  assign sel7     = func_r[FS_SEL7_HI:FS_SEL7_LO];
  assign lmode    = func_r[FS_LMODE_HI:FS_LMODE_LO];
  assign wbits    = i_reg_wdata[LINE_W-1:0];
  assign wr_func  = i_reg_wr && (i_reg_addr == OFS_FUNC);
  assign wr_dir   = i_reg_wr && (i_reg_addr == OFS_DIRECTION);
  assign wr_set   = i_reg_wr && (i_reg_addr == OFS_SET);
  assign wr_clear = i_reg_wr && (i_reg_addr == OFS_CLEAR);
  assign wr_level = i_reg_wr && (i_reg_addr == OFS_LEVEL);
  assign wr_mask  = i_reg_wr && (i_reg_addr == OFS_MASK);
  assign wr_turn  = i_reg_wr && (i_reg_addr == OFS_TURNAROUND);

  // Reserved code 11 falls back to general purpose rather than glitching
  assign line7_xcvr = func_r[FS_PIN_SEL] &&
                      (sel7 == XE_TRANSMIT || sel7 == XE_MATCH);

  // Sequencers for the two possible transceiver enable lines
  assign x5.sel_match  = (lmode == LM_XCVR_ADR);
  assign x5.delay      = turn_r;
  assign x5.polarity   = func_r[FS_POLARITY];
  assign x5.tx_active  = i_uart_tx_active;
  assign x5.addr_match = i_addr_match;
  assign x5.bit_tick   = i_bit_tick;
  assign x7.sel_match  = (sel7 == XE_MATCH);
  assign x7.delay      = turn_r;
  assign x7.polarity   = func_r[FS_POLARITY];
  assign x7.tx_active  = i_uart_tx_active;
  assign x7.addr_match = i_addr_match;
  assign x7.bit_tick   = i_bit_tick;

  xcvr_enable_gen #(
    .DELAY_W (TURN_W)
  ) u_xcvr5 (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .g          (x5.gen)
  );

  xcvr_enable_gen #(
    .DELAY_W (TURN_W)
  ) u_xcvr7 (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .g          (x7.gen)
  );

  // Alternate function routing per line
  always_comb begin
    alt_mask = '0;
    alt_oe   = '0;
    alt_val  = '0;
    if (func_r[FS_RX_TOGGLE]) begin
      alt_mask[LN_RX_TOGGLE] = 1'b1;
      alt_oe[LN_RX_TOGGLE]   = 1'b1;
      alt_val[LN_RX_TOGGLE]  = i_rx_toggle;
    end
    if (func_r[FS_TX_TOGGLE]) begin
      alt_mask[LN_TX_TOGGLE] = 1'b1;
      alt_oe[LN_TX_TOGGLE]   = 1'b1;
      alt_val[LN_TX_TOGGLE]  = i_tx_toggle;
    end
    if (func_r[FS_CLK_EN]) begin
      alt_mask[LN_CLOCK] = 1'b1;
      alt_oe[LN_CLOCK]   = 1'b1;
      alt_val[LN_CLOCK]  = i_clk_out;
    end
    if (line7_xcvr) begin
      alt_mask[LN_XCVR7] = 1'b1;
      alt_oe[LN_XCVR7]   = 1'b1;
      alt_val[LN_XCVR7]  = x7.drive;
    end
    // Line 5 always follows the low mode; reserved codes stay general
    case (lmode)
      LM_RTS_CTS: begin
        alt_mask[LN_REQUEST]  = 1'b1;
        alt_mask[LN_CLEAR_IN] = 1'b1;
        alt_oe[LN_REQUEST]    = 1'b1;
        alt_val[LN_REQUEST]   = i_flow_request;
      end
      LM_DTR_DSR: begin
        alt_mask[LN_TERMINAL] = 1'b1;
        alt_mask[LN_READY_IN] = 1'b1;
        alt_oe[LN_TERMINAL]   = 1'b1;
        alt_val[LN_TERMINAL]  = i_flow_terminal;
      end
      LM_XCVR_TX, LM_XCVR_ADR: begin
        alt_mask[LN_REQUEST] = 1'b1;
        alt_oe[LN_REQUEST]   = 1'b1;
        alt_val[LN_REQUEST]  = x5.drive;
      end
      default: begin
        alt_mask[LN_REQUEST] = 1'b0;
      end
    endcase
  end

  // General purpose outputs: direction counts only off alternates
  assign gp_out = ~alt_mask & dir_r;

  // Configuration registers; reserved upper bits are not stored
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      func_r <= FUNC_RST;
      dir_r  <= DIR_RST;
      mask_r <= MASK_RST;
      turn_r <= TURNAROUND_RST;
    end else begin
      if (wr_func) func_r <= wbits;
      if (wr_dir)  dir_r  <= wbits;
      if (wr_mask) mask_r <= wbits;
      if (wr_turn) turn_r <= i_reg_wdata[TURN_W-1:0];
    end
  end

  // Output latch; only general purpose output bits may change
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      gpio_r <= LEVEL_RST;
    end else if (wr_set) begin
      gpio_r <= gpio_r | (wbits & gp_out);
    end else if (wr_clear) begin
      gpio_r <= gpio_r & ~(wbits & gp_out);
    end else if (wr_level) begin
      gpio_r <= (gpio_r & ~gp_out) | (wbits & gp_out);
    end
  end

  // Pin drivers registered so outputs come straight from flops
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_line_out <= '0;
      o_line_oe  <= '0;
    end else begin
      o_line_out <= (alt_val & alt_oe) | (gpio_r & gp_out);
      o_line_oe  <= alt_oe | gp_out;
    end
  end

  // Two stage synchroniser; first stage feeds only the second
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= i_line_in;
      sync2_r <= sync1_r;
    end
  end

  // Previous sample; armed only once both compared samples are real,
  // else a pad idling high would look like a rise after reset
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      level_r  <= '0;
      arm_sh_r <= '0;
      armed_r  <= 1'b0;
    end else begin
      level_r  <= sync2_r;
      arm_sh_r <= {arm_sh_r[0], 1'b1};
      armed_r  <= arm_sh_r[1];
    end
  end

  // Any line not driven counts as input, alternate or not
  assign change_nxt = armed_r ?
    ((sync2_r ^ level_r) & ~o_line_oe & ~mask_r) : '0;

  // Change notification toward the packet builder
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_change_event <= 1'b0;
      o_change_lines <= '0;
    end else begin
      o_change_event <= |change_nxt;
      o_change_lines <= change_nxt;
    end
  end

  // Flow control inputs handed to the engines
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_clear_level <= 1'b0;
      o_ready_level <= 1'b0;
    end else begin
      o_clear_level <= sync2_r[LN_CLEAR_IN];
      o_ready_level <= sync2_r[LN_READY_IN];
    end
  end

  // Read port; write-only and unmapped offsets read zero
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_reg_rdata  <= '0;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        case (i_reg_addr)
          OFS_FUNC:       o_reg_rdata <= {6'h00, func_r};
          OFS_DIRECTION:  o_reg_rdata <= {6'h00, dir_r};
          OFS_LEVEL:      o_reg_rdata <= {6'h00, sync2_r};
          OFS_MASK:       o_reg_rdata <= {6'h00, mask_r};
          OFS_TURNAROUND: o_reg_rdata <= {12'h000, turn_r};
          default:        o_reg_rdata <= '0;
        endcase
      end
    end
  end

  rx_toggle_a :
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      func_r[FS_RX_TOGGLE] |=> o_line_oe[LN_RX_TOGGLE] &&
        o_line_out[LN_RX_TOGGLE] == $past(i_rx_toggle))
    else $error("line 9 not carrying receive toggle");

  tx_toggle_a :
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      func_r[FS_TX_TOGGLE] |=> o_line_oe[LN_TX_TOGGLE] &&
        o_line_out[LN_TX_TOGGLE] == $past(i_tx_toggle))
    else $error("line 8 not carrying transmit toggle");

  clock_out_a :
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      func_r[FS_CLK_EN] |=> o_line_out[LN_CLOCK] == $past(i_clk_out))
    else $error("line 6 not carrying clock");

  line7_gpio_a :
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (!func_r[FS_PIN_SEL] && !dir_r[LN_XCVR7]) |=> !o_line_oe[LN_XCVR7])
    else $error("line 7 driven while general input");

  line5_xcvr_a :
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (lmode == LM_XCVR_TX) |=> o_line_out[LN_REQUEST] == $past(x5.drive))
    else $error("line 5 not carrying transceiver enable");

  gp_direction_a :
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      1'b1 |=> ((o_line_oe & $past(gp_out)) == $past(gp_out)))
    else $error("general output line not enabled");

  set_write_a :
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      wr_set |=> ((gpio_r & $past(wbits & gp_out)) == $past(wbits & gp_out)))
    else $error("set write did not raise line");

  clear_write_a :
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      wr_clear |=> ((gpio_r & $past(wbits & gp_out)) == '0))
    else $error("clear write did not lower line");

  protect_alt_a :
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (wr_set || wr_clear || wr_level) |=>
        (((gpio_r ^ $past(gpio_r)) & ~$past(gp_out)) == '0))
    else $error("write changed non general output");

  masked_quiet_a :
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      o_change_event |-> ((o_change_lines & $past(mask_r)) == '0))
    else $error("masked line raised change event");

  change_seen_a :
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (armed_r && ((sync2_r ^ level_r) & ~o_line_oe & ~mask_r) != '0)
        |=> o_change_event)
    else $error("unmasked change not reported");

  line7_xcvr_a :
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      line7_xcvr |=> o_line_oe[LN_XCVR7] &&
        o_line_out[LN_XCVR7] == $past(x7.drive))
    else $error("line 7 not carrying transceiver enable");

  dtr_route_a :
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (lmode == LM_DTR_DSR) |=> o_line_oe[LN_TERMINAL] &&
        o_line_out[LN_TERMINAL] == $past(i_flow_terminal))
    else $error("line 2 not carrying terminal ready");

  level_write_a :
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      wr_level |=>
        ((gpio_r & $past(gp_out)) == $past(wbits & gp_out)))
    else $error("state write did not set general outputs");

  level_read_a :
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (i_reg_rd && i_reg_addr == OFS_LEVEL) |=>
        (o_reg_rdata == {6'h00, $past(sync2_r)}))
    else $error("state read not returning line levels");

endmodule // uart_pin_function_io_port

//--- line_pads.sv
// Far-side devices on the ten lines, resolving each pad level
`timescale 1ns/1ps
module line_pads
  import pinmux_pkg::*;
(
  input  wire logic [pinmux_pkg::LINE_W-1:0] i_out,
  input  wire logic [pinmux_pkg::LINE_W-1:0] i_oe,
  input  wire logic [pinmux_pkg::LINE_W-1:0] i_ext,
  output logic      [pinmux_pkg::LINE_W-1:0] o_pad
);
  // Port wins where it drives; far party never lets a line float
  assign o_pad = (i_oe & i_out) | (~i_oe & i_ext);
endmodule // line_pads

//--- uart_pin_function_io_port_bench.sv
// Bench for the line function multiplexer and general purpose port
`timescale 1ns/1ps
module uart_pin_function_io_port_bench;
  import pinmux_pkg::*;
  logic              core_clk = 1'b0;
  logic              rst_n    = 1'b0;
  logic              wr       = 1'b0;
  logic              rd       = 1'b0;
  logic [ADDR_W-1:0] addr     = 8'h00;
  logic [REG_W-1:0]  wdata    = 16'h0000;
  logic [LINE_W-1:0] ext      = 10'h000;
  logic              src_rx   = 1'b0;
  logic              src_tx   = 1'b0;
  logic              src_clk  = 1'b0;
  logic              src_req  = 1'b0;
  logic              src_term = 1'b0;
  logic              tx_on    = 1'b0;
  logic              adr_on   = 1'b0;
  logic              tick     = 1'b0;
  logic [REG_W-1:0]  rdata;
  logic              rvalid, clr_lvl, rdy_lvl, chg;
  logic [LINE_W-1:0] pad, lout, loe, chg_lines, rnd;
  logic [REG_W-1:0]  exp_q[$];
  logic [LINE_W-1:0] ev_q[$];
  int                num_errors  = 0;
  int                comparisons = 0;
  // Reset table: offset and value, unmapped 0x20 last
  logic [7:0]  rst_a[8] = '{8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10,
                            8'h11, 8'h20};
  logic [15:0] rst_v[8] = '{16'h0, 16'h0300, 16'h0, 16'h0, 16'h0, 16'h0,
                            16'h0100, 16'h0};
  // Function codes with expected drive and level, sources all high
  logic [9:0]  alt_fs[12] = '{10'h200, 10'h100, 10'h080,
    10'h001, 10'h002, 10'h003, 10'h00B, 10'h004,
    10'h031, 10'h051, 10'h020, 10'h000};
  logic [9:0]  alt_oe[12] = '{10'h200, 10'h100, 10'h040, 10'h020,
    10'h004, 10'h020, 10'h020, 10'h020, 10'h0A0, 10'h0A0, 10'h0, 10'h0};
  logic [9:0]  alt_lv[12] = '{10'h200, 10'h100, 10'h040, 10'h020,
    10'h004, 10'h020, 10'h000, 10'h020, 10'h0A0, 10'h0A0, 10'h0, 10'h0};

  uart_pin_function_io_port dut (
    .i_core_clk      (core_clk),
    .i_rst_n         (rst_n),
    .i_reg_wr        (wr),
    .i_reg_rd        (rd),
    .i_reg_addr      (addr),
    .i_reg_wdata     (wdata),
    .o_reg_rdata     (rdata),
    .o_reg_rvalid    (rvalid),
    .i_line_in       (pad),
    .o_line_out      (lout),
    .o_line_oe       (loe),
    .i_rx_toggle     (src_rx),
    .i_tx_toggle     (src_tx),
    .i_clk_out       (src_clk),
    .i_flow_request  (src_req),
    .i_flow_terminal (src_term),
    .i_uart_tx_active(tx_on),
    .i_addr_match    (adr_on),
    .i_bit_tick      (tick),
    .o_clear_level   (clr_lvl),
    .o_ready_level   (rdy_lvl),
    .o_change_event  (chg),
    .o_change_lines  (chg_lines)
  );

  line_pads pads (.i_out(lout), .i_oe(loe), .i_ext(ext), .o_pad(pad));

  // Free-running core clock, 5 ns period
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("Checks %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge core_clk);
    wr    <= 1'b0;
  endtask

  // Note the expected word first; the watcher compares it later
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge core_clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd   <= 1'b0;
  endtask

  // Pins settle two edges after a write; one more for margin
  task automatic pins(input logic [9:0] oe, input logic [9:0] lv);
    repeat (3) @(posedge core_clk);
    #1;
    check("line enables", 16'(loe), 16'(oe));
    check("line levels", 16'(lout & oe), 16'(lv));
  endtask

  task automatic wait_pin(input int b, input logic v, input int n);
    int k;
    for (k = 0; k < n; k++) begin
      @(posedge core_clk);
      #1;
      if (lout[b] === v) break;
    end
    check("pin wait", 16'(k < n), 16'h0001);
    if (k == n) wrap_up();
  endtask

  task automatic tick_once();
    @(posedge core_clk);
    tick <= 1'b1;
    @(posedge core_clk);
    tick <= 1'b0;
  endtask

  // Watcher: each answer or event takes the oldest note
  always @(posedge core_clk) begin
    if (rvalid === 1'b1) begin
      check("read data", rdata, exp_q.size() ? exp_q.pop_front() : 16'hDEAD);
    end
    if (chg === 1'b1) begin
      check("change lines", 16'(chg_lines),
            ev_q.size() ? 16'(ev_q.pop_front()) : 16'hFFFF);
    end
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    wrap_up();
  end

  // Main sequence; reserved select codes are never written
  initial begin
    void'($urandom(32'h00ED));
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      rd_reg(rst_a[k], rst_v[k]);
    end
    wr_reg(OFS_MASK, 16'h03FF);
    // Plain outputs through state, set and clear writes
    wr_reg(OFS_FUNC, 16'h0000);
    wr_reg(OFS_DIRECTION, 16'h03FF);
    rnd = 10'($urandom);
    wr_reg(OFS_LEVEL, {6'h00, rnd});
    pins(10'h3FF, rnd);
    rnd = rnd | 10'h00F;
    wr_reg(OFS_SET, 16'h000F);
    pins(10'h3FF, rnd);
    rnd = rnd & ~10'h0F0;
    wr_reg(OFS_CLEAR, 16'h00F0);
    pins(10'h3FF, rnd);
    rd_reg(OFS_LEVEL, {6'h00, rnd});
    // Upper lines turn input; a set on them must not drive
    wr_reg(OFS_DIRECTION, 16'h000F);
    @(posedge core_clk);
    ext <= 10'($urandom);
    wr_reg(OFS_SET, 16'h03F0);
    pins(10'h00F, rnd & 10'h00F);
    rd_reg(OFS_LEVEL, {6'h00, (ext & 10'h3F0) | (rnd & 10'h00F)});
    // Alternate functions ignore a zero direction
    wr_reg(OFS_DIRECTION, 16'h0000);
    @(posedge core_clk);
    {src_rx, src_tx, src_clk, src_req, src_term} <= 5'h1F;
    for (int k = 0; k < 12; k++) begin
      wr_reg(OFS_FUNC, {6'h00, alt_fs[k]});
      pins(alt_oe[k], alt_lv[k]);
    end
    // Line 5 enable, active low, held two bit times
    wr_reg(OFS_TURNAROUND, 16'h0002);
    wr_reg(OFS_FUNC, 16'h0003);
    wait_pin(5, 1'b1, 4);
    @(posedge core_clk);
    tx_on <= 1'b1;
    wait_pin(5, 1'b0, 4);
    @(posedge core_clk);
    tx_on <= 1'b0;
    repeat (8) @(posedge core_clk);
    tick_once();
    repeat (4) @(posedge core_clk);
    #1;
    check("held enable", 16'(lout[5]), 16'h0000);
    tick_once();
    wait_pin(5, 1'b1, 4);
    // Line 7 enable on address match, active high, no hold
    wr_reg(OFS_TURNAROUND, 16'h0000);
    wr_reg(OFS_FUNC, 16'h0059);
    wait_pin(7, 1'b0, 4);
    @(posedge core_clk);
    adr_on <= 1'b1;
    wait_pin(7, 1'b1, 4);
    @(posedge core_clk);
    adr_on <= 1'b0;
    wait_pin(7, 1'b0, 4);
    // Change events: masked line 9 moves alongside line 1
    wr_reg(OFS_FUNC, 16'h0000);
    @(posedge core_clk);
    ext <= 10'h000;
    repeat (4) @(posedge core_clk);
    wr_reg(OFS_MASK, 16'h03FC);
    ev_q.push_back(10'h002);
    @(posedge core_clk);
    ext <= 10'h202;
    repeat (6) @(posedge core_clk);
    rd_reg(OFS_LEVEL, 16'h0202);
    wr_reg(OFS_FUNC, 16'h0001);
    wr_reg(OFS_MASK, 16'h03EF);
    ev_q.push_back(10'h010);
    @(posedge core_clk);
    ext <= 10'h212;
    repeat (6) @(posedge core_clk);
    #1;
    check("clear level", 16'(clr_lvl), 16'h0001);
    wr_reg(OFS_FUNC, 16'h0002);
    @(posedge core_clk);
    ext <= 10'h21A;
    repeat (6) @(posedge core_clk);
    #1;
    check("ready level", 16'(rdy_lvl), 16'h0001);
    wr_reg(OFS_MASK, 16'h03FF);
    repeat (5) @(posedge core_clk);
    check("pending notes", 16'(exp_q.size() + ev_q.size()), 16'h0000);
    wrap_up();
  end
endmodule // uart_pin_function_io_port_bench
